// File: rtl/lpw_defines.svh
// Purpose: Constants for the low-power wake and restart controller
// Assumes: Core clock at 125 MHz
// Notes:   Counts and field positions only
`ifndef LPW_DEFINES_SVH
`define LPW_DEFINES_SVH

// ********************************************************
// Source vector layout
// ********************************************************
`define LPW_NUM_SRC        4
`define LPW_SRC_W          2
`define LPW_NO_SRC         2'h3

// ********************************************************
// Timing
// ********************************************************
`define LPW_OSC_START_CYC  2048
`define LPW_CNT_W          12

`endif

// File: rtl/lpw_pkg.sv
// Purpose: Types for the low-power wake and restart controller
// Assumes: Nothing beyond the defines header
// Notes:   Context and state enumerations
package lpw_pkg;

    typedef enum logic [1:0] {
        CTX_MAIN,
        CTX_IRQ,
        CTX_NMI
    } lpw_ctx_e;

    typedef enum logic [2:0] {
        ST_RUN,
        ST_WAIT,
        ST_STOP,
        ST_OSC,
        ST_RESUME
    } lpw_state_e;

endpackage

// File: rtl/lpw_if.sv
// Purpose: Wake-request bundle between selector and controller
// Assumes: Same clock on both ends
// Notes:   Carries the chosen normal source and qualifiers
`timescale 1ns/10ps
`default_nettype none
interface lpw_if;
    logic       anyReq;
    logic       anyStopReq;
    logic [1:0] topSrc;

    modport sel (output anyReq, output anyStopReq, output topSrc);
    modport ctl (input anyReq, input anyStopReq, input topSrc);
endinterface
`default_nettype wire

// File: rtl/lpw_prio_sel.sv
// Purpose: Fixed-priority pick of enabled normal interrupt requests
// Assumes: Inputs already synchronous to sys_clk
// Notes:   Index 0 is highest priority
`include "lpw_defines.svh"
`timescale 1ns/10ps
`default_nettype none
module lpw_prio_sel (
    input  wire logic [`LPW_NUM_SRC-1:0] srcPend,
    input  wire logic [`LPW_NUM_SRC-1:0] srcEnable,
    input  wire logic [`LPW_NUM_SRC-1:0] srcStopWake,
    input  wire logic                    globalIntEnable,
    lpw_if.sel                           req
);
    logic [`LPW_NUM_SRC-1:0] active;
    logic [`LPW_NUM_SRC-1:0] higher;

    genvar g;
    generate
        for (g = 0; g < `LPW_NUM_SRC; g++) begin : gSrc
            assign active[g] = srcPend[g] & srcEnable[g] & globalIntEnable;
            if (g == 0) begin : gFirst
                assign higher[g] = 1'b0;
            end else begin : gRest
                assign higher[g] = higher[g-1] | active[g-1];
            end
        end
    endgenerate

    assign req.anyReq     = |active;
    assign req.anyStopReq = |(active & srcStopWake);

    always_comb begin
        req.topSrc = `LPW_NO_SRC;
        for (int i = `LPW_NUM_SRC - 1; i >= 0; i--) begin
            if (active[i] && !higher[i]) begin
                req.topSrc = i[1:0];
            end
        end
    end
endmodule
`default_nettype wire

// File: rtl/lpw_ctrl.sv
// Purpose: Sequence exit from light wait and deep stop states
// Assumes: Core pulses sleep decode, handler entry and return
// Notes:   One clock domain, synchronous active-low reset
`include "lpw_defines.svh"
`timescale 1ns/10ps
`default_nettype none
module lpw_ctrl (
    input  wire logic                    sys_clk,
    input  wire logic                    resetn,
    input  wire logic                    sleepWait,
    input  wire logic                    sleepStop,
    input  wire logic                    handlerEnter,
    input  wire logic                    handlerNmi,
    input  wire logic                    handlerReturn,
    input  wire logic [`LPW_NUM_SRC-1:0] srcPend,
    input  wire logic [`LPW_NUM_SRC-1:0] srcEnable,
    input  wire logic [`LPW_NUM_SRC-1:0] srcStopWake,
    input  wire logic                    global_interrupt_enable,
    input  wire logic                    nmiPin,
    input  wire logic                    watchdogActive,
    input  wire logic                    external_stop_option,
    output logic                         coreHalt_q,
    output logic                         oscOff_q,
    output logic                         watchdogFreeze_q,
    output logic                         sleepSkip_q,
    output logic                         resumeNext_q,
    output logic                         takeNmi_q,
    output logic                         takeIrq_q,
    output logic [1:0]                   irqVector_q,
    output logic [1:0]                   sleepCtx_q
);
    // ********************************************************
    // Pin synchronisers
    // ********************************************************
    logic nmiMeta_q, nmiSync_q, nmiSyncD_q;
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            nmiMeta_q  <= 1'b1;
            nmiSync_q  <= 1'b1;
            nmiSyncD_q <= 1'b1;
        end else begin
            nmiMeta_q  <= nmiPin;
            nmiSync_q  <= nmiMeta_q;
            nmiSyncD_q <= nmiSync_q;
        end
    end
    // Falling edge on the pin raises a latched request
    logic nmiFall;
    assign nmiFall = nmiSyncD_q & ~nmiSync_q;

    // ********************************************************
    // Request selection
    // ********************************************************
    lpw_if req ();
    lpw_prio_sel uSel (
        .srcPend         (srcPend),
        .srcEnable       (srcEnable),
        .srcStopWake     (srcStopWake),
        .globalIntEnable (global_interrupt_enable),
        .req             (req)
    );

    // ********************************************************
    // Context tracking
    // ********************************************************
    lpw_pkg::lpw_ctx_e   ctx_q;
    lpw_pkg::lpw_ctx_e   outerCtx_q;
    lpw_pkg::lpw_state_e state_q;
    logic                nmiLatch_q;
    logic                resumeNmi_q;
    logic                nmiWake;
    logic                normWake;
    logic                sleepAny;

    assign sleepAny = sleepWait | sleepStop;
    // NMI wakes only with global enable
    assign nmiWake  = (nmiLatch_q | nmiFall) & global_interrupt_enable;
    assign normWake = (state_q == lpw_pkg::ST_STOP) ? req.anyStopReq
                                                    : req.anyReq;

    // NMI latch: new edge wins over the core's clear
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            nmiLatch_q <= 1'b0;
        end else if (nmiFall) begin
            nmiLatch_q <= 1'b1;
        end else if (takeNmi_q) begin
            nmiLatch_q <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            ctx_q      <= lpw_pkg::CTX_MAIN;
            outerCtx_q <= lpw_pkg::CTX_MAIN;
        end else if (handlerEnter) begin
            outerCtx_q <= ctx_q;
            ctx_q      <= handlerNmi ? lpw_pkg::CTX_NMI : lpw_pkg::CTX_IRQ;
        end else if (handlerReturn) begin
            ctx_q      <= (ctx_q == lpw_pkg::CTX_NMI) ? outerCtx_q
                                                      : lpw_pkg::CTX_MAIN;
            outerCtx_q <= lpw_pkg::CTX_MAIN;
        end
    end

    // ********************************************************
    // Sleep state machine
    // ********************************************************
    logic [`LPW_CNT_W-1:0] oscCnt_q;
    logic                  wakeNmiFirst_q;
    logic                  stopAllowed;
    assign stopAllowed = ~watchdogActive
                       | (external_stop_option & nmiSync_q);

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            state_q          <= lpw_pkg::ST_RUN;
            sleepCtx_q       <= 2'h0;
            coreHalt_q       <= 1'b0;
            oscOff_q         <= 1'b0;
            watchdogFreeze_q <= 1'b0;
            sleepSkip_q      <= 1'b0;
            oscCnt_q         <= '0;
            wakeNmiFirst_q   <= 1'b0;
        end else begin
            sleepSkip_q <= 1'b0;
            case (state_q)
                lpw_pkg::ST_RUN: begin
                    if (sleepAny && (req.anyReq || nmiLatch_q)) begin
                        sleepSkip_q <= 1'b1;
                    end else if (sleepAny) begin
                        sleepCtx_q <= ctx_q;
                        coreHalt_q <= 1'b1;
                        if (sleepStop && stopAllowed) begin
                            state_q          <= lpw_pkg::ST_STOP;
                            oscOff_q         <= 1'b1;
                            watchdogFreeze_q <= watchdogActive;
                        end else begin
                            state_q <= lpw_pkg::ST_WAIT;
                        end
                    end
                end
                lpw_pkg::ST_WAIT: begin
                    if (nmiWake || normWake) begin
                        wakeNmiFirst_q <= nmiWake;
                        state_q        <= lpw_pkg::ST_RESUME;
                    end
                end
                lpw_pkg::ST_STOP: begin
                    if (nmiWake || normWake) begin
                        wakeNmiFirst_q <= nmiWake;
                        oscOff_q       <= 1'b0;
                        oscCnt_q       <= `LPW_CNT_W'(`LPW_OSC_START_CYC - 1);
                        state_q        <= lpw_pkg::ST_OSC;
                    end
                end
                lpw_pkg::ST_OSC: begin
                    if (oscCnt_q == '0) begin
                        state_q <= lpw_pkg::ST_RESUME;
                    end else begin
                        oscCnt_q <= oscCnt_q - 1'b1;
                    end
                end
                default: begin
                    coreHalt_q       <= 1'b0;
                    watchdogFreeze_q <= 1'b0;
                    state_q          <= lpw_pkg::ST_RUN;
                end
            endcase
        end
    end

    // ********************************************************
    // Restart dispatch
    // ********************************************************
    // Each take and resume output is a one-cycle order to the core on leaving sleep,
    // plus later orders when an IRQ handler returns with requests left or the NMI handler run first returns.
    logic resumeDone;
    assign resumeDone = (state_q == lpw_pkg::ST_RESUME);

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            resumeNext_q <= 1'b0;
            takeNmi_q    <= 1'b0;
            takeIrq_q    <= 1'b0;
            irqVector_q  <= 2'h0;
            resumeNmi_q  <= 1'b0;
        end else begin
            resumeNext_q <= 1'b0;
            takeNmi_q    <= 1'b0;
            takeIrq_q    <= 1'b0;
            if (resumeDone) begin
                case (sleepCtx_q)
                    lpw_pkg::CTX_NMI: begin
                        resumeNext_q <= 1'b1;
                    end
                    lpw_pkg::CTX_IRQ: begin
                        if (wakeNmiFirst_q) begin
                            takeNmi_q   <= 1'b1;
                            resumeNmi_q <= 1'b1;
                        end else begin
                            resumeNext_q <= 1'b1;
                        end
                    end
                    default: begin
                        if (wakeNmiFirst_q) begin
                            takeNmi_q <= 1'b1;
                        end else begin
                            takeIrq_q   <= 1'b1;
                            irqVector_q <= req.topSrc;
                        end
                    end
                endcase
            end else if (handlerReturn && resumeNmi_q) begin
                resumeNmi_q  <= 1'b0;
                resumeNext_q <= 1'b1;
            end else if (handlerReturn && ctx_q == lpw_pkg::CTX_IRQ
                         && req.anyReq) begin
                takeIrq_q   <= 1'b1;
                irqVector_q <= req.topSrc;
            end
        end
    end

    // ********************************************************
    // Checks
    // ********************************************************
    logic stopHoldOk;
    assign stopHoldOk = (state_q != lpw_pkg::ST_OSC) || coreHalt_q;

    // Counts cycles spent in start-up, independent of the down counter
    logic [`LPW_CNT_W-1:0] oscStay_q;
    always_ff @(posedge sys_clk) begin
        if (!resetn || state_q != lpw_pkg::ST_OSC) begin
            oscStay_q <= '0;
        end else begin
            oscStay_q <= oscStay_q + 1'b1;
        end
    end

    skip_no_halt_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        sleepSkip_q |-> !$rose(coreHalt_q))
        else $error("sleep entered while request pending");

    osc_delay_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        $rose(state_q == lpw_pkg::ST_OSC)
        |-> (state_q == lpw_pkg::ST_OSC) [*8])
        else $error("oscillator delay cut short");

    osc_len_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        (state_q == lpw_pkg::ST_OSC ##1 state_q == lpw_pkg::ST_RESUME)
        |-> $past(oscStay_q) == `LPW_CNT_W'(`LPW_OSC_START_CYC - 1))
        else $error("oscillator delay not 2048 cycles");

    ctx_hold_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        (coreHalt_q && $past(coreHalt_q)) |-> $stable(sleepCtx_q))
        else $error("sleep context changed during sleep");

    nmi_ctx_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        (resumeDone && sleepCtx_q == lpw_pkg::CTX_NMI)
        |=> resumeNext_q && !takeIrq_q && !takeNmi_q)
        else $error("nmi context resume wrong");

    main_irq_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        (resumeDone && sleepCtx_q == lpw_pkg::CTX_MAIN && !wakeNmiFirst_q)
        |=> takeIrq_q && !resumeNext_q)
        else $error("main context wake not serviced");

    irq_resume_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        (resumeDone && sleepCtx_q == lpw_pkg::CTX_IRQ && !wakeNmiFirst_q)
        |=> resumeNext_q && !takeIrq_q)
        else $error("irq context not resumed");

    irq_nmi_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        (resumeDone && sleepCtx_q == lpw_pkg::CTX_IRQ && wakeNmiFirst_q)
        |=> takeNmi_q && resumeNmi_q)
        else $error("nmi not run first in irq context");

    nmi_gen_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        (state_q == lpw_pkg::ST_WAIT && !global_interrupt_enable)
        |=> state_q != lpw_pkg::ST_RESUME)
        else $error("woke with global enable clear");

    stop_wake_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        (state_q == lpw_pkg::ST_STOP && !req.anyStopReq && !nmiWake)
        |=> state_q == lpw_pkg::ST_STOP)
        else $error("stop left without stop-capable source");

    wdg_stop_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        (state_q == lpw_pkg::ST_RUN && sleepStop && !sleepSkip_q
         && watchdogActive && !external_stop_option && !req.anyReq
         && !nmiLatch_q)
        |=> state_q != lpw_pkg::ST_STOP)
        else $error("stop entered with watchdog active");

    halt_osc_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        stopHoldOk)
        else $error("core released during start-up");

    ret_prio_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        (handlerReturn && !resumeDone && !resumeNmi_q
         && ctx_q == lpw_pkg::CTX_IRQ && req.anyReq)
        |=> takeIrq_q && irqVector_q == $past(req.topSrc))
        else $error("pending irq not dispatched by priority");

    wait_c: cover property (@(posedge sys_clk) disable iff (!resetn)
        state_q == lpw_pkg::ST_WAIT ##[1:20] resumeDone);
    stop_c: cover property (@(posedge sys_clk) disable iff (!resetn)
        state_q == lpw_pkg::ST_OSC ##1 resumeDone);
    skip_c: cover property (@(posedge sys_clk) disable iff (!resetn)
        sleepSkip_q);
    nmi_first_c: cover property (@(posedge sys_clk) disable iff (!resetn)
        takeNmi_q && resumeNmi_q);
endmodule
`default_nettype wire

// File: testbench/lpw_core_model.sv
// Purpose: Core-side partner that answers dispatch pulses with entries
// Assumes: Dispatch pulses last one cycle
// Notes:   Bench asks for entries and returns; model adds the core latency
`timescale 1ns/10ps
`default_nettype none
module lpw_core_model (
    input  wire logic sys_clk,
    input  wire logic resetn,
    input  wire logic takeIrq,
    input  wire logic takeNmi,
    input  wire logic tbEnter,
    input  wire logic tbNmi,
    input  wire logic tbReturn,
    output logic      handlerEnter,
    output logic      handlerNmi,
    output logic      handlerReturn
);
    // ****************************************************
    // Handler entry and return
    // ****************************************************
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            handlerEnter  <= 1'b0;
            handlerReturn <= 1'b0;
            handlerNmi    <= 1'b0;
        end else begin
            handlerEnter  <= takeIrq | takeNmi | tbEnter;
            handlerReturn <= tbReturn;
            // Qualifier toggles when not valid, so it cannot be trusted
            if (takeIrq | takeNmi | tbEnter) begin
                handlerNmi <= takeNmi | tbNmi;
            end else begin
                handlerNmi <= ~handlerNmi;
            end
        end
    end
endmodule
`default_nettype wire

// File: testbench/test_low_power_wake_restart_control.sv
// Purpose: Self-checking bench for the wake and restart controller
// Assumes: Inputs change on the falling edge
// Notes:   Each scenario starts from a fresh reset
`timescale 1ns/10ps
`default_nettype none
module test_low_power_wake_restart_control;
    logic       sys_clk, resetn, sleepWait, sleepStop, tbEnter, tbNmi;
    logic       tbReturn, gie, nmiPin, wdg, opt;
    logic       handlerEnter, handlerNmi, handlerReturn;
    logic [3:0] pend, en, stopWake;
    logic       coreHalt_q, oscOff_q, watchdogFreeze_q, sleepSkip_q;
    logic       resumeNext_q, takeNmi_q, takeIrq_q;
    logic [1:0] irqVector_q, sleepCtx_q;
    int         n_errors, checks_done, n;

    lpw_ctrl dut_u (.sys_clk(sys_clk), .resetn(resetn),
        .sleepWait(sleepWait), .sleepStop(sleepStop),
        .handlerEnter(handlerEnter), .handlerNmi(handlerNmi),
        .handlerReturn(handlerReturn), .srcPend(pend), .srcEnable(en),
        .srcStopWake(stopWake), .global_interrupt_enable(gie),
        .nmiPin(nmiPin), .watchdogActive(wdg),
        .external_stop_option(opt), .coreHalt_q(coreHalt_q),
        .oscOff_q(oscOff_q), .watchdogFreeze_q(watchdogFreeze_q),
        .sleepSkip_q(sleepSkip_q), .resumeNext_q(resumeNext_q),
        .takeNmi_q(takeNmi_q), .takeIrq_q(takeIrq_q),
        .irqVector_q(irqVector_q), .sleepCtx_q(sleepCtx_q));

    lpw_core_model core_u (.sys_clk(sys_clk), .resetn(resetn),
        .takeIrq(takeIrq_q), .takeNmi(takeNmi_q), .tbEnter(tbEnter),
        .tbNmi(tbNmi), .tbReturn(tbReturn), .handlerEnter(handlerEnter),
        .handlerNmi(handlerNmi), .handlerReturn(handlerReturn));

    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    // ****************************************************
    // Shared tasks
    // ****************************************************
    task automatic stop_test();
        if (n_errors == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk(string nm, logic [1:0] e, logic [1:0] g);
        checks_done++;
        if (g !== e) begin
            n_errors++;
            $display("Error %s expected %0h seen %0h", nm, e, g);
        end
    endtask

    task automatic chk_cnt(string nm, int lo, int hi, int g);
        checks_done++;
        if (g < lo || g > hi) begin
            n_errors++;
            $display("Error %s expected %0d..%0d seen %0d", nm, lo, hi, g);
        end
    endtask

    function automatic logic sel(int k);
        case (k)
            0: sel = takeIrq_q;
            1: sel = takeNmi_q;
            2: sel = resumeNext_q;
            default: sel = ~coreHalt_q;
        endcase
    endfunction

    // Waits for event k; the count of edges comes back in n
    task automatic wt(string nm, int k, int lim, output int cnt);
        logic seen;
        seen = 1'b0;
        cnt = 0;
        while (!seen && cnt < lim) begin
            @(posedge sys_clk);
            #1;
            cnt++;
            seen = (sel(k) === 1'b1);
        end
        chk(nm, 2'h1, {1'b0, seen});
    endtask

    task automatic quiet(string nm, int k, int cyc);
        logic hit;
        hit = 1'b0;
        repeat (cyc) begin
            @(posedge sys_clk);
            #1;
            hit = hit | (sel(k) !== 1'b0);
        end
        chk(nm, 2'h0, {1'b0, hit});
    endtask

    task automatic rst();
        @(negedge sys_clk);
        {sleepWait, sleepStop, tbEnter, tbNmi, tbReturn, wdg, opt} = '0;
        {gie, nmiPin, resetn} = 3'h6;
        pend = 4'h0;
        en = 4'hF;
        stopWake = 4'h5;
        repeat (5) @(negedge sys_clk);
        resetn = 1'b1;
    endtask

    task automatic slp(logic stop);
        @(negedge sys_clk);
        sleepWait = ~stop;
        sleepStop = stop;
        @(negedge sys_clk);
        {sleepWait, sleepStop} = 2'h0;
    endtask

    task automatic ent(logic nmi);
        @(negedge sys_clk);
        tbEnter = 1'b1;
        tbNmi = nmi;
        @(negedge sys_clk);
        tbEnter = 1'b0;
        @(negedge sys_clk);
    endtask

    task automatic ret();
        @(negedge sys_clk);
        tbReturn = 1'b1;
        @(negedge sys_clk);
        tbReturn = 1'b0;
    endtask

    task automatic nmi();
        @(negedge sys_clk);
        nmiPin = 1'b0;
        repeat (3) @(negedge sys_clk);
        nmiPin = 1'b1;
    endtask

    task automatic setp(logic [3:0] v);
        @(negedge sys_clk);
        pend = v;
    endtask

    // ****************************************************
    // Scenarios
    // ****************************************************
    task automatic t_main();
        rst();
        slp(1'b0);
        chk("ctx", 2'h0, sleepCtx_q); // context latched
        setp(4'h2);
        wt("irq", 0, 4, n); // any source wakes wait
        chk("vec", 2'h1, irqVector_q); // handler of waking source
        chk("halt", 2'h0, {1'b0, coreHalt_q}); // core runs again
        setp(4'h0);
        ret();
        quiet("noirq", 0, 10); // nothing else pending
    endtask

    task automatic t_skip();
        for (int s = 0; s < 2; s++) begin
            rst();
            setp(4'h8);
            slp(s[0]);
            chk("skip", 2'h1, {1'b0, sleepSkip_q}); // sleep skipped
            chk("halt", 2'h0, {1'b0, coreHalt_q}); // no low power
        end
    endtask

    task automatic t_irq();
        rst();
        ent(1'b0);
        slp(1'b0);
        chk("ctx", 2'h1, sleepCtx_q); // context latched
        setp(4'hA);
        wt("resume", 2, 4, n); // handler continues
        chk("noirq", 2'h0, {1'b0, takeIrq_q}); // stays in handler
        ret();
        wt("irq", 0, 4, n); // pending served after return
        chk("vec", 2'h1, irqVector_q); // highest priority first
        setp(4'h8);
        ret();
        wt("irq", 0, 4, n); // next priority
        chk("vec", 2'h3, irqVector_q); // lowest last
    endtask

    task automatic t_nmi_wake();
        rst();
        ent(1'b0);
        slp(1'b0);
        nmi();
        wt("nmi", 1, 12, n); // NMI handler first
        ret();
        wt("resume", 2, 4, n); // then original handler
    endtask

    task automatic t_nmi_ctx();
        rst();
        ent(1'b1);
        slp(1'b0);
        quiet("held", 3, 5); // stays asleep
        chk("ctx", 2'h2, sleepCtx_q); // context held
        setp(4'h1);
        wt("resume", 2, 4, n); // any source wakes
        quiet("noirq", 0, 10); // other request not served
    endtask

    task automatic t_gie();
        rst();
        @(negedge sys_clk);
        gie = 1'b0;
        slp(1'b0);
        nmi();
        quiet("nowake", 3, 30); // NMI cannot wake
    endtask

    task automatic t_stop();
        rst();
        slp(1'b1);
        chk("osc", 2'h1, {1'b0, oscOff_q}); // stop with watchdog off
        setp(4'h2);
        quiet("nowake", 3, 50); // source not stop-capable
        setp(4'h6);
        wt("irq", 0, 2100, n); // stop-capable source wakes
        chk_cnt("startup", 2049, 2053, n); // oscillator start-up
    endtask

    task automatic t_wdg();
        rst();
        @(negedge sys_clk);
        wdg = 1'b1;
        slp(1'b1);
        chk("osc", 2'h0, {1'b0, oscOff_q}); // stop becomes wait
        chk("halt", 2'h1, {1'b0, coreHalt_q}); // core waits
        setp(4'h2);
        wt("irq", 0, 4, n); // wait-speed wake
        rst();
        @(negedge sys_clk);
        {wdg, opt} = 2'h3;
        slp(1'b1);
        chk("osc", 2'h1, {1'b0, oscOff_q}); // option allows stop
        chk("frz", 2'h1, {1'b0, watchdogFreeze_q}); // watchdog frozen
    endtask

    initial begin
        #100000;
        n_errors++;
        stop_test();
    end

    initial begin
        {resetn, sleepWait, sleepStop, tbEnter, tbNmi, tbReturn} = '0;
        {gie, nmiPin, wdg, opt} = 4'hC;
        pend = 4'h0;
        en = 4'hF;
        stopWake = 4'h5;
        n_errors = 0;
        checks_done = 0;
        t_main();
        t_skip();
        t_irq();
        t_nmi_wake();
        t_nmi_ctx();
        t_gie();
        t_stop();
        t_wdg();
        stop_test();
    end
endmodule
`default_nettype wire
